// ### logic/angle_encoder_port.sv
// Behaviour
// - A wake-up is flagged when the angle moves more than a programmable 0..127 LSB threshold, default 4, set over the serial port.
// - The angle is also given as an 8-bit pwm with a period near 141.35 us and high time near 140.8 us at full scale.
// - When the rotation reverses, the reported angle holds until the input has moved two LSB beyond the last code.
// - The otp programming pulse is timed inside the device and lasts 2 to 4 us.
// - In 2-wire mode a transfer ends when no rising clock comes within 20 to 24 us of the last one.
// - Command bits are presented by the controller and sampled by the device on rising clock edges.
// - On reads the device drives the data line from half a clock after the last command bit through the data phase.
// - Dropping chip select releases the data line and ends the transfer.
// - The 3-bit gain comes from otp unless a serial write has overridden it through a mirror register.
// - Each transfer is a 5-bit command then 16 data bits, both msb first.
// - Pwm high time is code plus one steps out of a 257-step period.
// - While the angle is invalid the pwm output stays low.
`timescale 1ns/1ps
module angle_encoder_port
    import encoder_port_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clkEn,
    input wire serial_in_t serialPins,
    input wire logic twoWireMode,
    input wire logic [7:0] angleIn,
    input wire logic angleValid,
    input wire logic [2:0] otpGain,
    input wire logic wakeClear,
    input wire logic progStart,
    output serial_out_t serialDataIo,
    output logic pwmOut,
    output logic wakeOut,
    output logic wakeOe,
    output logic [2:0] gainCode,
    output logic progPulse,
    output logic [7:0] reportedAngle
);

    localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);
    localparam int PROG_W = $clog2(PROG_CYC + 1);
    localparam int LSB_W = $clog2(PWM_LSB_CYC + 1);
    localparam logic [TO_W-1:0] TO_LAST = TO_W'(TIMEOUT_CYCLES - 1);
    localparam logic [PROG_W-1:0] PROG_LAST = PROG_W'(PROG_CYC - 1);
    localparam logic [LSB_W-1:0] LSB_LAST = LSB_W'(PWM_LSB_CYC - 1);
    localparam logic [8:0] STEP_LAST = 9'(PWM_STEPS - 1);
    localparam logic [4:0] CMD_LAST = 5'(CMD_BITS - 1);
    localparam logic [4:0] DATA_LAST = 5'(DATA_BITS - 1);

    // pin synchronisers; stage one feeds stage two only
    serial_in_t pinMeta;
    serial_in_t pinSync;
    serial_in_t pinPrev;

    port_state_t state;
    logic [4:0] bitCount;
    logic [4:0] txCount;
    logic [15:0] rxShift;
    logic [15:0] txShift;
    logic [4:0] command;
    logic driving;
    logic dataBit;
    logic [TO_W-1:0] idleCount;

    logic [6:0] wakeLsb;
    logic [2:0] gainMirror;
    logic gainOverride;

    logic lastDirDown;
    logic [7:0] refAngle;
    logic refLoaded;
    logic wakeFlag;

    logic [PROG_W-1:0] progCount;

    logic [LSB_W-1:0] lsbDiv;
    logic [8:0] pwmStep;
    logic [7:0] pwmCode;
    logic pwmValid;

    wire clkRise = pinSync.sclk & ~pinPrev.sclk;
    wire clkFall = ~pinSync.sclk & pinPrev.sclk;
    wire selectDrop = pinPrev.select & ~pinSync.select;
    wire frameAllowed = twoWireMode | pinSync.select;
    wire timedOut = twoWireMode && state != PORT_IDLE
        && idleCount == TO_LAST;
    wire frameEnd = (~twoWireMode & (selectDrop | ~pinSync.select))
        | timedOut;
    wire isWrite = command[CMD_WRITE_BIT];
    wire [4:0] cmdNow = {rxShift[3:0], pinSync.data};
    wire lastCmdRise = state == PORT_CMD && clkRise
        && bitCount == CMD_LAST;
    wire lastDataRise = state == PORT_DATA && clkRise && isWrite
        && bitCount == DATA_LAST;
    wire [15:0] custWord = {wakeLsb, gainCode, 6'h00};
    wire [15:0] angleWord = {reportedAngle, 7'h00, angleValid};
    wire [15:0] response = (cmdNow == CMD_READ_CUST) ? custWord : angleWord;
    wire readFall = state == PORT_DATA && clkFall && !isWrite
        && txCount != 5'(DATA_BITS);

    // oe is cut by the raw select pin, since two sync stages at this
    // clock would far exceed the float time
    assign serialDataIo.oe = driving & (twoWireMode | serialPins.select);
    assign serialDataIo.data = dataBit;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            pinMeta <= '0;
            pinSync <= '0;
            pinPrev <= '0;
        end
        else if (clkEn)
        begin
            pinMeta <= serialPins;
            pinSync <= pinMeta;
            pinPrev <= pinSync;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            idleCount <= '0;
        else if (clkEn)
        begin
            if (clkRise || state == PORT_IDLE)
                idleCount <= '0;
            else if (idleCount != TO_LAST)
                idleCount <= idleCount + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= PORT_IDLE;
            bitCount <= '0;
            rxShift <= '0;
            command <= '0;
        end
        else if (clkEn)
        begin
            if (frameEnd)
                state <= PORT_IDLE;
            else
            begin
                unique case (state)
                    PORT_IDLE:
                    begin
                        if (frameAllowed && clkRise)
                        begin
                            rxShift <= {15'h0000, pinSync.data};
                            bitCount <= 5'h01;
                            state <= PORT_CMD;
                        end
                    end
                    PORT_CMD:
                    begin
                        if (clkRise)
                        begin
                            rxShift <= {rxShift[14:0], pinSync.data};
                            bitCount <= bitCount + 1'b1;
                            if (lastCmdRise)
                            begin
                                command <= cmdNow;
                                bitCount <= '0;
                                state <= PORT_DATA;
                            end
                        end
                    end
                    PORT_DATA:
                    begin
                        if (clkRise && isWrite && bitCount != 5'(DATA_BITS))
                        begin
                            rxShift <= {rxShift[14:0], pinSync.data};
                            bitCount <= bitCount + 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    // read data leaves on falling clocks, half a period after the rise
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            driving <= 1'b0;
            dataBit <= 1'b0;
            txShift <= '0;
            txCount <= '0;
        end
        else if (clkEn)
        begin
            if (frameEnd)
            begin
                driving <= 1'b0;
                txCount <= '0;
            end
            else if (lastCmdRise)
            begin
                txShift <= response;
                txCount <= '0;
            end
            else if (readFall)
            begin
                driving <= 1'b1;
                dataBit <= txShift[15];
                txShift <= {txShift[14:0], 1'b0};
                txCount <= txCount + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            wakeLsb <= WAKE_LSB_RESET;
            gainMirror <= GAIN_RESET;
            gainOverride <= 1'b0;
        end
        else if (clkEn && lastDataRise && command == CMD_WRITE_CUST)
        begin
            wakeLsb <= rxShift[WLSB_MSB-1:WLSB_LSB-1];
            gainMirror <= rxShift[GAIN_MSB-1:GAIN_LSB-1];
            gainOverride <= 1'b1;
        end
    end

    assign gainCode = gainOverride ? gainMirror : otpGain;

    // direction tracking for the reported code
    wire [7:0] angleDiff = angleIn - reportedAngle;
    wire diffDown = angleDiff[7];
    wire [7:0] diffMag = diffDown ? 8'(-angleDiff) : angleDiff;
    wire moveOk = angleDiff != 8'h00
        && (diffDown == lastDirDown || diffMag > 8'(HYST_LSB));
    // reference takes the code being reported next, not the stale one
    wire [7:0] next_reportedAngle = (angleValid && moveOk)
        ? angleIn : reportedAngle;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            reportedAngle <= 8'h00;
            lastDirDown <= 1'b0;
        end
        else if (clkEn && angleValid && moveOk)
        begin
            reportedAngle <= angleIn;
            lastDirDown <= diffDown;
        end
    end

    wire [7:0] wakeDiff = reportedAngle - refAngle;
    wire [7:0] wakeMag = wakeDiff[7] ? 8'(-wakeDiff) : wakeDiff;
    wire wakeEvent = refLoaded && wakeMag > {1'b0, wakeLsb};

    // a clear re-arms against the present angle; a new event still wins
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            refAngle <= 8'h00;
            refLoaded <= 1'b0;
            wakeFlag <= 1'b0;
        end
        else if (clkEn)
        begin
            if (angleValid && (!refLoaded || wakeClear))
            begin
                refAngle <= next_reportedAngle;
                refLoaded <= 1'b1;
            end
            if (wakeEvent)
                wakeFlag <= 1'b1;
            else if (wakeClear)
                wakeFlag <= 1'b0;
        end
    end

    assign wakeOut = 1'b0;
    assign wakeOe = wakeFlag;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            progPulse <= 1'b0;
            progCount <= '0;
        end
        else if (clkEn)
        begin
            if (!progPulse && progStart)
            begin
                progPulse <= 1'b1;
                progCount <= '0;
            end
            else if (progPulse)
            begin
                progCount <= progCount + 1'b1;
                if (progCount == PROG_LAST)
                    progPulse <= 1'b0;
            end
        end
    end

    // code is latched per period so a moving angle cannot split a pulse
    wire stepEnd = lsbDiv == LSB_LAST;
    wire periodEnd = stepEnd && pwmStep == STEP_LAST;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            lsbDiv <= '0;
            pwmStep <= '0;
            pwmCode <= 8'h00;
            pwmValid <= 1'b0;
            pwmOut <= 1'b0;
        end
        else if (clkEn)
        begin
            lsbDiv <= stepEnd ? '0 : lsbDiv + 1'b1;
            if (periodEnd)
            begin
                pwmStep <= '0;
                pwmCode <= reportedAngle;
                pwmValid <= angleValid;
            end
            else if (stepEnd)
                pwmStep <= pwmStep + 1'b1;
            pwmOut <= pwmValid && angleValid
                && pwmStep <= {1'b0, pwmCode};
        end
    end

endmodule

// ### logic/encoder_port_pkg.sv
package encoder_port_pkg;

    localparam int CLK_HZ = 20_000_000;

    // serial framing
    localparam int CMD_BITS = 5;
    localparam int DATA_BITS = 16;
    localparam logic [4:0] CMD_WRITE_CUST = 5'h17;
    localparam logic [4:0] CMD_READ_CUST = 5'h07;
    localparam int CMD_WRITE_BIT = 4;

    // write-cust field layout
    localparam int WLSB_MSB = 15;
    localparam int WLSB_LSB = 9;
    localparam int GAIN_MSB = 8;
    localparam int GAIN_LSB = 6;

    // reset values
    localparam logic [6:0] WAKE_LSB_RESET = 7'h04;
    localparam logic [2:0] GAIN_RESET = 3'h0;

    // 2-wire timeout, least time rounded up
    localparam int TIMEOUT_NS = 20_000;
    localparam int TIMEOUT_CYC = (TIMEOUT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // programming pulse, aimed mid-window of 2 to 4 us
    localparam int PROG_MIN_NS = 2_000;
    localparam int PROG_MAX_NS = 4_000;
    localparam int PROG_NS = (PROG_MIN_NS + PROG_MAX_NS) / 2;
    localparam int PROG_CYC = PROG_NS * (CLK_HZ / 1_000_000) / 1000;

    // pwm: one step of 0.55 us (0.556 us rounded down to 11 clocks), period of 257 steps
    localparam int PWM_LSB_PS = 556_000;
    localparam int PWM_LSB_CYC = PWM_LSB_PS / (1_000_000_000 / (CLK_HZ / 1000));
    localparam int PWM_STEPS = 257;

    // hysteresis on direction reversal
    localparam int HYST_LSB = 1;

    typedef enum logic [1:0]
    {
        PORT_IDLE = 2'b00,
        PORT_CMD = 2'b01,
        PORT_DATA = 2'b11
    } port_state_t;

    typedef struct packed
    {
        logic select;
        logic sclk;
        logic data;
    } serial_in_t;

    typedef struct packed
    {
        logic data;
        logic oe;
    } serial_out_t;

endpackage

// ### tb/angle_encoder_port_sva.sv
`timescale 1ns/1ps
module angle_encoder_port_sva
    import encoder_port_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clkEn,
    input wire serial_in_t serialPins,
    input wire logic twoWireMode,
    input wire logic [7:0] angleIn,
    input wire logic angleValid,
    input wire logic [2:0] otpGain,
    input wire logic wakeClear,
    input wire logic progStart,
    input wire serial_out_t serialDataIo,
    input wire logic pwmOut,
    input wire logic wakeOut,
    input wire logic wakeOe,
    input wire logic [2:0] gainCode,
    input wire logic progPulse,
    input wire logic [7:0] reportedAngle
);
    int progCnt = 0;
    int hiCnt = 0;
    int since = 0;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    // plain counters, no reset needed: all three sources sit low during reset
    always_ff @(posedge clk_sys)
    begin
        progCnt <= progPulse ? progCnt + 1 : 0;
        hiCnt <= pwmOut ? hiCnt + 1 : 0;
        since <= $rose(serialPins.sclk) ? 0 : since + 1;
    end
    a_prog_width:
        assert property ($fell(progPulse) |-> progCnt == PROG_CYC)
        else $error("programming pulse length wrong");
    a_float_deselect:
        assert property (!twoWireMode && !serialPins.select
            |-> !serialDataIo.oe) else $error("data line driven unselected");
    a_wake_level: assert property (wakeOe |-> !wakeOut)
        else $error("wake line not pulled low");
    a_wake_hold: assert property (wakeOe && !wakeClear |=> wakeOe)
        else $error("wake flag lost without clear");
    a_pwm_invalid: assert property (!angleValid |=> !pwmOut)
        else $error("pwm high while angle invalid");
    a_pwm_steps:
        assert property ($fell(pwmOut) && $past(angleValid)
            |-> hiCnt % PWM_LSB_CYC == 0 && hiCnt <= 256 * PWM_LSB_CYC)
        else $error("pwm high time not whole steps");
    a_timeout_late:
        assert property (twoWireMode && serialDataIo.oe
            |-> since <= TIMEOUT_CYCLES * 6 / 5 + 4)
        else $error("2-wire frame outlived its timeout");
    a_timeout_early:
        assert property (twoWireMode && $fell(serialDataIo.oe)
            |-> since >= TIMEOUT_CYCLES) else $error("2-wire frame ended early");
    c_prog: cover property (progPulse);
    c_wake: cover property ($rose(wakeOe));
    c_timeout: cover property (twoWireMode && $fell(serialDataIo.oe));
endmodule

// ### tb/serial_master.sv
`timescale 1ns/1ps
module serial_master
    import encoder_port_pkg::*;
(
    input wire serial_out_t serial_data_io,
    output wire serial_in_t pins
);
    logic sel = 1'b0;
    logic sck = 1'b0;
    logic drv = 1'b0;
    logic bitv = 1'b0;
    logic lastL = 1'b0;
    // no pull on the line: once released it shows the inverse of its last level
    wire line = serial_data_io.oe ? serial_data_io.data : (drv ? bitv : ~lastL);
    assign pins = '{select: sel, sclk: sck, data: line};
    always @(serial_data_io.oe, serial_data_io.data, drv, bitv)
    begin
        if (serial_data_io.oe)
            lastL = serial_data_io.data;
        else if (drv)
            lastL = bitv;
    end
    // sclk rests low between frames; 400 ns a bit, off the system phase
    task automatic xfer(input logic [4:0] c, input logic [15:0] w,
        input logic two, output logic [15:0] r);
        logic [20:0] word;
        word = {c, w};
        #13 sel = ~two;
        drv = 1'b1;
        for (int i = 20; i >= 0; i--)
        begin
            bitv = word[i];
            #100 sck = 1'b1;
            if (i < 16)
                r[i] = line;
            #100 drv = drv && (i != 16 || c[4]);
            #100 sck = 1'b0;
            #100;
        end
        sel = 1'b0;
        drv = 1'b0;
    endtask
endmodule

// ### tb/test_angle_encoder_port.sv
`timescale 1ns/1ps
module test_angle_encoder_port
    import encoder_port_pkg::*;
;
    localparam int TO_CYC = 20; // short timeout keeps the run brief
    typedef struct {int kind; logic [15:0] v;} note_t;
    note_t notes[$];
    string what[5] = '{"read", "wake", "gain", "angle", "pwm"};
    logic [15:0] hyst[6] = '{16'h6464, 16'h6565, 16'h6465, 16'h6363,
        16'h6463, 16'h6666};
    logic [7:0] codes[3] = '{8'h00, 8'h7F, 8'hFF};
    event got;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic clkEn = 1'b1;
    logic twoWireMode = 1'b0;
    logic [7:0] angleIn = 8'h64;
    logic angleValid = 1'b1;
    logic [2:0] otpGain = 3'h0;
    logic wakeClear = 1'b0;
    logic progStart = 1'b0;
    serial_in_t serialPins;
    serial_out_t serialDataIo;
    logic pwmOut, wakeOut, wakeOe, progPulse;
    logic [2:0] gainCode;
    logic [7:0] reportedAngle;
    logic [15:0] rd;
    logic [6:0] wl;
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    int hiLen = 0;
    int hiLast = 0;
    angle_encoder_port #(.TIMEOUT_CYCLES(TO_CYC)) dut (.*);
    serial_master m (.serial_data_io(serialDataIo), .pins(serialPins));
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(int n, int k, logic [15:0] v);
        repeat (n) @(posedge clk_sys);
        #1;
        notes.push_back('{k, v});
        ->got;
    endtask
    task automatic ser(logic [4:0] c, logic [15:0] w, logic [15:0] x);
        if (!c[CMD_WRITE_BIT])
            notes.push_back('{0, x});
        m.xfer(c, w, twoWireMode, rd);
        if (!c[CMD_WRITE_BIT])
            ->got;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic angle_chk(logic [7:0] a, int k, logic [15:0] v);
        @(posedge clk_sys);
        angleIn <= a;
        check(6, k, v);
    endtask
    // two cycles: a standing event wins over the first clear cycle
    task automatic clear_wake;
        @(posedge clk_sys);
        wakeClear <= 1'b1;
        repeat (2) @(posedge clk_sys);
        wakeClear <= 1'b0;
    endtask
    initial
    begin
        forever #25 clk_sys = ~clk_sys;
    end
    // ceiling well above the roughly 28k cycles the sequence needs
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        hiLen <= pwmOut ? hiLen + 1 : 0;
        if (!pwmOut && hiLen > 0)
            hiLast <= hiLen;
        if (cyc == 90000)
        begin
            n_errors++;
            end_of_test();
        end
    end
    always @(got)
    begin
        note_t e;
        logic [15:0] seen;
        e = notes.pop_front();
        case (e.kind)
            0: seen = rd;
            1: seen = 16'(wakeOe);
            2: seen = 16'(gainCode);
            3: seen = 16'(reportedAngle);
            default: seen = 16'(hiLast);
        endcase
        samples_checked++;
        if (seen !== e.v)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what[e.kind],
                e.v, seen);
        end
    end
    initial
    begin
        void'($urandom(32'h362D));
        otpGain = 3'($urandom);
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        check(3, 2, 16'(otpGain));
        foreach (hyst[i])
            angle_chk(hyst[i][15:8], 3, 16'(hyst[i][7:0]));
        check(1, 1, 16'h0000);
        clear_wake();
        angle_chk(8'h6A, 1, 16'h0000);
        angle_chk(8'h6B, 1, 16'h0001);
        clear_wake();
        check(3, 1, 16'h0000);
        $display("angle and wake test done");
        for (int g = 0; g < 8; g++)
        begin
            wl = (g == 7) ? 7'h7F : 7'(g);
            ser(CMD_WRITE_CUST, {wl, 3'(g), 6'($urandom)}, 16'h0000);
            check(2, 2, 16'(g));
            ser(CMD_READ_CUST, 16'h0000, {wl, 3'(g), 6'h00});
        end
        angle_chk(8'hEA, 1, 16'h0000);
        angle_chk(8'hEB, 1, 16'h0001);
        ser(CMD_WRITE_CUST, 16'h0080, 16'h0000);
        clear_wake();
        check(3, 1, 16'h0000);
        angle_chk(8'hEC, 1, 16'h0001);
        $display("threshold and gain test done");
        for (int t = 2; t >= 0; t--)
        begin
            @(posedge clk_sys);
            twoWireMode <= (t > 0);
            @(posedge clk_sys);
            ser(5'h00, 16'h0000, 16'hEC01);
            repeat (3 * TO_CYC) @(posedge clk_sys);
        end
        $display("serial read test done");
        for (int p = 0; p < 2; p++)
        begin
            @(posedge clk_sys);
            progStart <= 1'b1;
            @(posedge clk_sys);
            progStart <= 1'b0;
            repeat (10) @(posedge clk_sys);
        end
        repeat (60) @(posedge clk_sys);
        foreach (codes[i])
        begin
            @(posedge clk_sys);
            angleIn <= codes[i];
            repeat (2 * PWM_STEPS * PWM_LSB_CYC) @(posedge clk_sys);
            @(negedge pwmOut);
            check(2, 4, 16'((codes[i] + 1) * PWM_LSB_CYC));
        end
        @(posedge clk_sys);
        angleValid <= 1'b0;
        repeat (PWM_STEPS * PWM_LSB_CYC) @(posedge clk_sys);
        angleValid <= 1'b1;
        $display("programming and pwm test done");
        end_of_test();
    end
endmodule
bind angle_encoder_port angle_encoder_port_sva
    #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk (.*);
